/* hw/cedt_can_error_diag_timestamp.sv */
/*
  can error counters, error diagnostic capture, bit time stamp counter, bit timing and post-frame
  processing budget, with an axi4-lite register slave.
  assumes a bit-level protocol engine outside drives the field, bit and event strobes, all synchronous
  to ref_clk, and an external transceiver on the bus pins.
*/
module cedt_can_error_diag_timestamp
  import cedt_pkg::*;
#(
  parameter int NUM_BUF = CEDT_NUM_BUF
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // can pins
  input  wire logic                bus_rx_pin,
  output logic                     bus_tx_pin,
  // protocol engine side
  input  wire logic                tx_bit,
  input  wire logic                transmitting,
  input  wire logic                in_ack_slot,
  input  wire logic                in_error_flag,
  input  wire logic                field_start,
  input  wire cedt_field_t         field_code,
  input  wire logic [5:0]          field_len,
  input  wire cedt_err_t           err_event,
  input  wire logic                tx_success,
  input  wire logic                rx_success,
  input  wire logic                frame_done,
  input  wire logic [3:0]          frame_buf,
  input  wire logic                remote_rx,
  input  wire logic [NUM_BUF-1:0]  reply_armed,
  output logic                     rx_level,
  output logic                     bit_tick,
  output logic [NUM_BUF-1:0]       reply_once_set,
  output logic                     sched_strobe,
  output logic                     post_busy,
  output logic                     error_irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  rec_r, tec_r;
  cedt_diag_t  diag_r;
  logic [5:0]  bit_idx_r;
  logic [15:0] ts_r;
  logic [4:0]  gcfg_r;
  logic [5:0]  psc_r;
  logic [3:0]  seg1_r;
  logic [2:0]  seg2_r;
  logic        epend_r;
  logic [15:0] stamp_r [NUM_BUF];
  logic        clr_epend;

  // ----------------------------------------------------------------
  // pins: polarity and enable gating
  // ----------------------------------------------------------------
  wire enabled = gcfg_r[CEDT_GC_ENABLE_POS];
  wire rx_in   = enabled ? (bus_rx_pin ^ gcfg_r[CEDT_GC_RXPOL_POS]) : 1'b1;
  // a receiver only drives dominant in the ack slot or an active error flag
  wire drive   = enabled & (transmitting | in_ack_slot | in_error_flag) ? tx_bit : 1'b1;

  // registered pin drive and receive level
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_tx_pin <= 1'b1;
      rx_level   <= 1'b1;
    end else begin
      bus_tx_pin <= drive ^ gcfg_r[CEDT_GC_TXPOL_POS];
      rx_level   <= rx_in;
    end
  end

  // ----------------------------------------------------------------
  // bit timing: sync + seg1 + seg2 quanta of prescaler clocks
  // ----------------------------------------------------------------
  logic [6:0] psc_cnt_r;
  logic [4:0] tq_cnt_r;
  // one bit wider so the largest prescaler setting does not wrap
  wire  [6:0] psc_eff = {1'b0, psc_r} + {1'b0, CEDT_PSC_MIN};
  wire  [4:0] tq_bit  = 5'd1 + {1'b0, seg1_r} + 5'd1 + {2'b0, seg2_r} + 5'd1;
  wire        tq_end  = (psc_cnt_r == psc_eff - 7'd1);

  // quantum and bit counters
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      psc_cnt_r <= 7'h00;
      tq_cnt_r  <= 5'h00;
      bit_tick  <= 1'b0;
    end else if (!enabled) begin
      psc_cnt_r <= 7'h00;
      tq_cnt_r  <= 5'h00;
      bit_tick  <= 1'b0;
    end else begin
      psc_cnt_r <= tq_end ? 7'h00 : psc_cnt_r + 7'd1;
      bit_tick  <= tq_end && (tq_cnt_r == tq_bit - 5'd1);
      if (tq_end) begin
        tq_cnt_r <= (tq_cnt_r == tq_bit - 5'd1) ? 5'h00 : tq_cnt_r + 5'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // error counters with fault confinement
  // ----------------------------------------------------------------
  wire [7:0] err_step = err_event.severe ? 8'h08 : 8'h01;
  logic [7:0] rec_nxt, tec_nxt;

  // next counter values
  always_comb begin
    rec_nxt = rec_r;
    tec_nxt = tec_r;
    if (err_event.rx_err) begin
      rec_nxt = (rec_r > 8'hff - err_step) ? 8'hff : rec_r + err_step;
    end else if (rx_success && rec_r != 8'h00) begin
      rec_nxt = (rec_r > 8'h7f) ? 8'h77 : rec_r - 8'h01;
    end
    if (err_event.tx_err) begin
      tec_nxt = (tec_r > 8'hff - err_step) ? 8'hff : tec_r + err_step;
    end else if (tx_success && tec_r != 8'h00) begin
      tec_nxt = tec_r - 8'h01;
    end
  end

  wire any_err = err_event.rx_err | err_event.tx_err | err_event.stuff | err_event.crc;

  // counters and error pending flag
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rec_r   <= CEDT_RST_ERROR_COUNT[15:8];
      tec_r   <= CEDT_RST_ERROR_COUNT[7:0];
      epend_r <= 1'b0;
    end else begin
      rec_r <= rec_nxt;
      tec_r <= tec_nxt;
      if ((rec_nxt != rec_r) || (tec_nxt != tec_r)) begin
        epend_r <= 1'b1; // set wins over clear
      end else if (clr_epend) begin
        epend_r <= 1'b0;
      end
    end
  end

  // error interrupt output
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      error_irq <= 1'b0;
    end else begin
      error_irq <= epend_r & gcfg_r[CEDT_GC_EIEN_POS];
    end
  end

  // ----------------------------------------------------------------
  // diagnostic capture
  // ----------------------------------------------------------------
  // bit index within the current field
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_idx_r <= 6'h00;
    end else if (field_start) begin
      bit_idx_r <= field_len - 6'd1;
    end else if (bit_tick) begin
      bit_idx_r <= bit_idx_r - 6'd1;
    end
  end

  // snapshot of the most recent error, all fields at once
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      diag_r <= CEDT_RST_ERROR_DIAG;
    end else if (any_err) begin
      diag_r.rsvd             <= 1'b0;
      diag_r.drive            <= bus_tx_pin;
      diag_r.sampled_rx_level <= rx_in;
      diag_r.crc              <= err_event.crc;
      diag_r.stuff            <= err_event.stuff;
      diag_r.was_transmitter  <= transmitting;
      diag_r.error_bit_index  <= bit_idx_r;
      diag_r.error_field_code <= field_code;
    end
  end

  // ----------------------------------------------------------------
  // time stamp counter and per-buffer stamps
  // ----------------------------------------------------------------
  wire good_frame = tx_success | rx_success;
  wire buf0_clear = gcfg_r[CEDT_GC_TSCLR_POS] && good_frame && (frame_buf == 4'h0);

  // free-running count of can bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ts_r <= CEDT_RST_TIMESTAMP;
    end else if (buf0_clear) begin
      ts_r <= 16'h0000;
    end else if (bit_tick) begin
      ts_r <= ts_r + 16'd1;
    end
  end

  // stamp store, one word per buffer
  generate
    for (genvar b = 0; b < NUM_BUF; b++) begin : g_stamp
      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          stamp_r[b] <= 16'h0000;
        end else if (good_frame && frame_buf == 4'(b)) begin
          stamp_r[b] <= ts_r;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // post-frame processing: copy, auto-reply updates, scheduling
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CEDT_P_IDLE, CEDT_P_COPY, CEDT_P_REPLY, CEDT_P_SCHED} cedt_post_t;
  cedt_post_t         post_r;
  logic [5:0]         post_cnt_r;
  logic [NUM_BUF-1:0] reply_left_r;
  logic [3:0]         reply_pick;

  // lowest pending armed buffer
  always_comb begin
    reply_pick = 4'h0;
    for (int i = NUM_BUF - 1; i >= 0; i--) begin
      if (reply_left_r[i]) begin
        reply_pick = 4'(i);
      end
    end
  end

  // sequencer with fixed cycle budgets
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      post_r         <= CEDT_P_IDLE;
      post_cnt_r     <= 6'h00;
      reply_left_r   <= '0;
      reply_once_set <= '0;
      sched_strobe   <= 1'b0;
      post_busy      <= 1'b0;
    end else begin
      reply_once_set <= '0;
      sched_strobe   <= 1'b0;
      case (post_r)
        CEDT_P_IDLE: begin
          if (frame_done) begin
            post_r       <= CEDT_P_COPY;
            post_cnt_r   <= CEDT_CYC_COPY - 6'd1;
            reply_left_r <= remote_rx ? reply_armed : '0;
            post_busy    <= 1'b1;
          end
        end
        CEDT_P_COPY: begin
          if (post_cnt_r != 6'h00) begin
            post_cnt_r <= post_cnt_r - 6'd1;
          end else if (reply_left_r != '0) begin
            post_r     <= CEDT_P_REPLY;
            post_cnt_r <= CEDT_CYC_REPLY - 6'd1;
          end else begin
            post_r     <= CEDT_P_SCHED;
            post_cnt_r <= CEDT_CYC_SCHEDULE - 6'd1;
          end
        end
        CEDT_P_REPLY: begin
          if (post_cnt_r != 6'h00) begin
            post_cnt_r <= post_cnt_r - 6'd1;
          end else begin
            reply_once_set[reply_pick] <= 1'b1; // armed to replied-once
            reply_left_r[reply_pick]   <= 1'b0;
            if ((reply_left_r & ~(NUM_BUF'(1) << reply_pick)) != '0) begin
              post_cnt_r <= CEDT_CYC_REPLY - 6'd1;
            end else begin
              post_r     <= CEDT_P_SCHED;
              post_cnt_r <= CEDT_CYC_SCHEDULE - 6'd1;
            end
          end
        end
        CEDT_P_SCHED: begin
          if (post_cnt_r != 6'h00) begin
            post_cnt_r <= post_cnt_r - 6'd1;
          end else begin
            sched_strobe <= 1'b1; // done 19 to 64 clocks after frame_done is taken, 64 with all 15 buffers replying
            post_busy    <= 1'b0;
            post_r       <= CEDT_P_IDLE;
          end
        end
        default: post_r <= CEDT_P_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic       aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  wire        do_write  = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign      clr_epend = do_write && aw_addr_r == CEDT_ADDR_STATUS && w_strb_r[0] && w_data_r[CEDT_ST_EPEND_POS];
  wire        wr_ok     = aw_addr_r == CEDT_ADDR_GLOBAL_CONFIG || aw_addr_r == CEDT_ADDR_BIT_TIMING
                          || aw_addr_r == CEDT_ADDR_STATUS;

  // write address and data capture, response
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~w_have_r & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10; // slverr on read-only or unmapped
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers, held across disable
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gcfg_r <= CEDT_RST_GLOBAL_CFG;
      psc_r  <= CEDT_RST_PRESCALER;
      seg1_r <= CEDT_RST_SEG1;
      seg2_r <= CEDT_RST_SEG2;
    end else if (do_write && w_strb_r[0]) begin
      if (aw_addr_r == CEDT_ADDR_GLOBAL_CONFIG) begin
        gcfg_r <= w_data_r[4:0];
      end
      if (aw_addr_r == CEDT_ADDR_BIT_TIMING) begin
        psc_r  <= w_data_r[5:0];
        seg1_r <= w_data_r[11:8];
        seg2_r <= w_data_r[14:12];
      end
    end
  end

  // read mux
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr >= CEDT_ADDR_STAMP_BASE && s_axi_araddr[1:0] == 2'b00
        && s_axi_araddr < CEDT_ADDR_STAMP_BASE + 8'(4 * NUM_BUF)) begin
      rd_word[15:0] = stamp_r[4'((s_axi_araddr - CEDT_ADDR_STAMP_BASE) >> 2)];
    end else begin
      case (s_axi_araddr)
        CEDT_ADDR_ERROR_COUNT:   rd_word[15:0] = {rec_r, tec_r};
        CEDT_ADDR_ERROR_DIAG:    rd_word[15:0] = diag_r;
        CEDT_ADDR_TIMESTAMP:     rd_word[15:0] = ts_r;
        CEDT_ADDR_GLOBAL_CONFIG: rd_word[4:0]  = gcfg_r;
        CEDT_ADDR_BIT_TIMING:    rd_word[14:0] = {seg2_r, seg1_r, 2'b00, psc_r};
        CEDT_ADDR_STATUS:        rd_word[1:0]  = {post_busy, epend_r};
        default:                 rd_ok         = 1'b0;
      endcase
    end
  end

  // read channel
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : cedt_can_error_diag_timestamp

/* hw/cedt_pkg.sv */
/*
  package for the can error, diagnostic and time stamp block: register map, field layout, reset values,
  field codes and timing constants.
  assumes a 20 mhz module clock and a 32-bit axi4-lite register bus.
*/
package cedt_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CEDT_ADDR_ERROR_COUNT   = 8'h00;
  localparam logic [7:0] CEDT_ADDR_ERROR_DIAG    = 8'h04;
  localparam logic [7:0] CEDT_ADDR_TIMESTAMP     = 8'h08;
  localparam logic [7:0] CEDT_ADDR_GLOBAL_CONFIG = 8'h0c;
  localparam logic [7:0] CEDT_ADDR_BIT_TIMING    = 8'h10;
  localparam logic [7:0] CEDT_ADDR_STATUS        = 8'h14;
  localparam logic [7:0] CEDT_ADDR_STAMP_BASE    = 8'h40;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CEDT_EC_REC_LSB    = 8;
  localparam int CEDT_DG_FIELD_LSB  = 0;
  localparam int CEDT_DG_BIT_LSB    = 4;
  localparam int CEDT_DG_TXE_POS    = 10;
  localparam int CEDT_DG_STUFF_POS  = 11;
  localparam int CEDT_DG_CRC_POS    = 12;
  localparam int CEDT_DG_MON_POS    = 13;
  localparam int CEDT_DG_DRIVE_POS  = 14;
  localparam int CEDT_GC_ENABLE_POS = 0;
  localparam int CEDT_GC_TSCLR_POS  = 1;
  localparam int CEDT_GC_TXPOL_POS  = 2;
  localparam int CEDT_GC_RXPOL_POS  = 3;
  localparam int CEDT_GC_EIEN_POS   = 4;
  localparam int CEDT_ST_EPEND_POS  = 0;
  localparam int CEDT_ST_BUSY_POS   = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CEDT_RST_ERROR_COUNT = 16'h0000;
  localparam logic [15:0] CEDT_RST_ERROR_DIAG  = 16'h0000;
  localparam logic [15:0] CEDT_RST_TIMESTAMP   = 16'h0000;
  localparam logic [4:0]  CEDT_RST_GLOBAL_CFG  = 5'h00;
  localparam logic [5:0]  CEDT_RST_PRESCALER   = 6'h00;
  localparam logic [3:0]  CEDT_RST_SEG1        = 4'h1;
  localparam logic [2:0]  CEDT_RST_SEG2        = 3'h0;

  // ----------------------------------------------------------------
  // timing: post-frame work in module clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] CEDT_CYC_COPY     = 6'h11; // hidden buffer copy, 17
  localparam logic [5:0] CEDT_CYC_REPLY    = 6'h03; // auto-reply status update, 3
  localparam logic [5:0] CEDT_CYC_SCHEDULE = 6'h02; // transmit scheduling, 2
  localparam logic [5:0] CEDT_PSC_MIN      = 6'h02; // prescaler floor
  localparam int         CEDT_NUM_BUF      = 15;

  // error field codes in hardware order
  typedef enum logic [3:0] {
    CEDT_F_ERROR, CEDT_F_ERROR_DEL, CEDT_F_ERROR_ECHO, CEDT_F_BUS_IDLE,
    CEDT_F_ACK, CEDT_F_EOF, CEDT_F_INTERMISSION, CEDT_F_SUSPEND,
    CEDT_F_SOF, CEDT_F_ARBITRATION, CEDT_F_IDE, CEDT_F_EXT_ARB,
    CEDT_F_R1R0, CEDT_F_DLC, CEDT_F_DATA, CEDT_F_CRC
  } cedt_field_t;

  // error event reported by the protocol engine
  typedef struct packed {
    logic tx_err;   // error counted against the transmitter
    logic rx_err;   // error counted against the receiver
    logic severe;   // counts 8 rather than 1
    logic stuff;
    logic crc;
  } cedt_err_t;

  // diagnostic snapshot layout
  typedef struct packed {
    logic        rsvd;
    logic        drive;
    logic        sampled_rx_level;
    logic        crc;
    logic        stuff;
    logic        was_transmitter;
    logic [5:0]  error_bit_index;
    cedt_field_t error_field_code;
  } cedt_diag_t;

endpackage : cedt_pkg

/* verification/cedt_bus_model.sv */
/* can bus seen through a transceiver: the node's transmit pin wired-and with the other nodes.
   assumes receive polarity is handled inside the block and no transceiver delay. */
module cedt_bus_model (
  input  wire logic tx_pin,
  input  wire logic others_bit,
  output logic      rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // dominant 0 from any node wins, recessive only when all release
  assign rx_pin = tx_pin & others_bit;
endmodule : cedt_bus_model

/* verification/cedt_monitor.sv */
/* port assertions for the can error, diagnostic and time stamp block.
   assumes one clock ref_clk and the async active-low reset_n. */
module cedt_monitor
  import cedt_pkg::*;
#(
  parameter int NUM_BUF = CEDT_NUM_BUF
) (
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               bus_tx_pin,
  input wire logic               tx_bit,
  input wire logic               transmitting,
  input wire logic               in_ack_slot,
  input wire logic               in_error_flag,
  input wire logic               bit_tick,
  input wire logic               frame_done,
  input wire logic               sched_strobe,
  input wire logic [NUM_BUF-1:0] reply_armed,
  input wire logic [NUM_BUF-1:0] reply_once_set
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // receiver with no ack slot, error flag or config write under way
  sequence quiet_s;
    !transmitting && !in_ack_slot && !in_error_flag && !s_axi_wvalid;
  endsequence
  rx_silent_a: assert property (quiet_s [*4] |=> $stable(bus_tx_pin))
    else $error("transmit pin moved while only receiving");
  tx_follow_a: assert property (transmitting && $past(transmitting) && $changed(tx_bit) |=> $changed(bus_tx_pin))
    else $error("transmit pin did not follow the driven bit");
  tick_gap_a: assert property (bit_tick |=> !bit_tick [*7])
    else $error("can bits closer than eight clocks");
  post_budget_a: assert property (frame_done |-> ##[17:66] sched_strobe)
    else $error("post-frame work outside its budget");
  reply_sub_a: assert property (reply_once_set != '0 |-> (reply_once_set & ~reply_armed) == '0)
    else $error("unarmed buffer moved to replied-once");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : cedt_monitor

bind cedt_can_error_diag_timestamp cedt_monitor #(.NUM_BUF(NUM_BUF)) u_mon (.*);

/* verification/test_can_error_diag_timestamp.sv */
/* self-checking bench: register reads, error capture, post-frame work, time stamps, pin polarity.
   assumes the block package and a wired-and bus model on the far side. */
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module test_can_error_diag_timestamp
  import cedt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, p;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bus_rx_pin, bus_tx_pin;
  logic        tx_bit, transmitting, in_ack_slot, in_error_flag, field_start, tx_success, rx_success, frame_done;
  logic        remote_rx, rx_level, bit_tick, sched_strobe, post_busy, error_irq, other_bit;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, frame_buf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [14:0] reply_armed, reply_once_set, acc, armed [3];
  logic [5:0]  field_len;
  cedt_field_t field_code;
  cedt_err_t   err_event, ev;
  integer      seed = 41, n_mismatch = 0, samples_checked = 0, cyc = 0, inbound_error_tally = 0, outbound_error_tally = 0, ts = 0, n;
  cedt_can_error_diag_timestamp u_dut (.*);
  cedt_bus_model u_bus (.tx_pin(bus_tx_pin), .others_bit(other_bit), .rx_pin(bus_rx_pin));
  // clock, cycle ceiling and bit count model
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (bit_tick === 1'b1) ts++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic wait_tick();
    do @(posedge ref_clk); while (bit_tick !== 1'b1);
  endtask : wait_tick
  // bus read, response and data compared together; bready and rready stay high
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    `CHK({s_axi_rresp, s_axi_rdata}, {er, e})
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    `CHK(s_axi_bresp, er)
  endtask : wr
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_bit, transmitting} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {in_ack_slot, in_error_flag, field_start, tx_success, rx_success, frame_done, remote_rx} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frame_buf, reply_armed, field_len, err_event} = '0;
    field_code = CEDT_F_ERROR;
    s_axi_wstrb = 4'hf;
    other_bit = 1'b1;
    reset_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(CEDT_ADDR_ERROR_COUNT, 32'h0, 2'b00);
    rd_chk(CEDT_ADDR_ERROR_DIAG, 32'h0, 2'b00);
    rd_chk(8'h30, 32'h0, 2'b10);
    wr(CEDT_ADDR_ERROR_COUNT, 32'h1234, 2'b10);
    $display("reset and access test done");
    wr(CEDT_ADDR_BIT_TIMING, 32'h0102, 2'b00);
    wr(CEDT_ADDR_GLOBAL_CONFIG, 32'h11, 2'b00);
    for (int i = 0; i < 16; i++) begin
      wait_tick();
      `CHK(error_irq, 1'b0)
      field_start <= 1'b1;
      field_code <= cedt_field_t'(i);
      field_len <= 6'(3 + $unsigned($random(seed)) % 61);
      {in_ack_slot, transmitting, tx_bit, other_bit} <= 4'($random(seed));
      @(posedge ref_clk);
      field_start <= 1'b0;
      wait_tick();
      wait_tick();
      @(posedge ref_clk);
      ev = 5'($random(seed)) | 5'b01000;
      err_event <= ev;
      @(posedge ref_clk);
      err_event <= '0;
      n = ev.severe ? 8 : 1;
      if (ev.tx_err) outbound_error_tally += n;
      if (ev.rx_err) inbound_error_tally += n;
      p = (transmitting | in_ack_slot) ? tx_bit : 1'b1;
      repeat (2) @(posedge ref_clk);
      rd_chk(CEDT_ADDR_ERROR_DIAG, {17'h0, p, p & other_bit, ev.crc, ev.stuff, transmitting, field_len - 6'd3, 4'(i)}, 2'b00);
      rd_chk(CEDT_ADDR_ERROR_COUNT, {16'h0, 8'(inbound_error_tally), 8'(outbound_error_tally)}, 2'b00);
      `CHK(error_irq, 1'b1)
      wr(CEDT_ADDR_STATUS, 32'h1, 2'b00);
    end
    transmitting <= 1'b0;
    in_ack_slot <= 1'b0;
    $display("error capture test done");
    armed = '{15'($random(seed)), 15'h7fff, 15'h0};
    foreach (armed[j]) begin
      reply_armed <= armed[j];
      remote_rx <= 1'b1;
      frame_done <= 1'b1;
      @(posedge ref_clk);
      frame_done <= 1'b0;
      acc = '0;
      for (n = 0; n < 80 && sched_strobe !== 1'b1; n++) begin
        @(posedge ref_clk);
        acc |= reply_once_set;
      end
      `CHK(acc, armed[j])
      `CHK(n >= 17 && n <= 66, 1'b1)
    end
    $display("post-frame test done");
    wr(CEDT_ADDR_BIT_TIMING, 32'h7f3f, 2'b00);
    wait_tick();
    repeat (3) @(posedge ref_clk);
    rd_chk(CEDT_ADDR_TIMESTAMP, 32'(ts[15:0]), 2'b00);
    frame_buf <= 4'h5;
    rx_success <= 1'b1;
    @(posedge ref_clk);
    rx_success <= 1'b0;
    rd_chk(CEDT_ADDR_STAMP_BASE + 8'h14, 32'(ts[15:0]), 2'b00);
    wr(CEDT_ADDR_GLOBAL_CONFIG, 32'h13, 2'b00);
    frame_buf <= 4'h0;
    tx_success <= 1'b1;
    @(posedge ref_clk);
    tx_success <= 1'b0;
    ts = 0;
    rd_chk(CEDT_ADDR_TIMESTAMP, 32'h0, 2'b00);
    $display("time stamp test done");
    `CHK(post_busy, 1'b0)
    wr(CEDT_ADDR_GLOBAL_CONFIG, 32'h0, 2'b00);
    other_bit <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(rx_level, 1'b1)
    wr(CEDT_ADDR_GLOBAL_CONFIG, 32'h0d, 2'b00);
    other_bit <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK({bus_tx_pin, rx_level}, 2'b01)
    $display("pin polarity test done");
    stop_test();
  end
endmodule : test_can_error_diag_timestamp
